// ==== design/net_mode_select_ext_match.sv ====
`timescale 1ns/1ns
`default_nettype none

module net_mode_select_ext_match
	import netsel_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic adapter_reset_in,
	input wire logic net_select_0,
	input wire logic net_select_1,
	input wire logic net_select_2,
	input wire logic board_test_in_a,
	input wire logic board_test_in_b,
	input wire logic board_test_in_c,
	input wire logic ext_no_match_n,
	input wire logic ext_match_found,
	input wire logic frame_start_in,
	input wire logic copy_decide_in,
	input wire logic frame_end_in,
	input wire logic internal_match_in,
	input wire logic [REG_ADDR_W-1:0] reg_addr_in,
	input wire logic [REG_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [REG_DATA_W-1:0] reg_rdata_out,
	output logic [2:0] net_mode_out,
	output logic token_ring_mode_out,
	output logic full_duplex_out,
	output logic mode_reserved_out,
	output logic outputs_enable_out,
	output logic input_pullup_en_out,
	output logic test_pullup_en_out,
	output logic copy_frame_out,
	output logic addr_recognized_frame_copied_bits_out,
	output logic copy_all_frames_mode_out
);

	typedef struct packed {
		net_mode_t mode_r;
		logic copy_all_frames_mode_r;
		dec_state_t dec_r;
		logic copy_r;
		logic ari_r;
		logic [REG_DATA_W-1:0] rdata_r;
	} blk_state_t;

	blk_state_t st_r;
	blk_state_t st_nxt;
	logic [SYNC_W-1:0] pins_s;
	net_mode_t decoded;
	logic test_mode;
	logic fail_s;
	logic match_s;
	logic ext_ok;

	// Every pin is off-domain, so all of them go through two flops
	pin_sync #(
		.WIDTH(SYNC_W),
		.RESET_VAL(SYNC_RESET)
	) u_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.pins_in({ext_match_found, ext_no_match_n, board_test_in_c, board_test_in_b,
			board_test_in_a, net_select_2, net_select_1, net_select_0}),
		.sync_out(pins_s)
	);

	assign fail_s = pins_s[IX_FAIL];
	assign match_s = pins_s[IX_MATCH];
	assign test_mode = !pins_s[IX_TEST_A] && !pins_s[IX_TEST_B];
	// Fail wins; both low is still armed and counts as no match; open pins read high
	assign ext_ok = match_s && !fail_s;

	always_comb begin
		decoded = MODE_RESERVED;
		if (pins_s[IX_SEL2]) begin
			unique case ({pins_s[IX_SEL0], pins_s[IX_SEL1]})
				2'h0: decoded = MODE_ETH_FULL;
				2'h1: decoded = MODE_TR_16;
				2'h2: decoded = MODE_ETH_HALF;
				2'h3: decoded = MODE_TR_4;
			endcase
		end
	end

	always_comb begin
		st_nxt = st_r;
		// Tracking during reset freezes the mode at release; straps move only then
		if (adapter_reset_in) begin
			st_nxt.mode_r = decoded;
		end
		if (reg_wr_in && reg_addr_in == CTRL_OFFSET) begin
			st_nxt.copy_all_frames_mode_r = reg_wdata_in[CTRL_CAF_BIT];
		end
		unique case (st_r.dec_r)
			DEC_IDLE: begin
				if (frame_start_in) begin
					st_nxt.dec_r = DEC_ARMED;
				end
			end
			DEC_ARMED: begin
				if (frame_end_in) begin
					st_nxt.dec_r = DEC_IDLE;
				end else if (copy_decide_in) begin
					st_nxt.dec_r = DEC_DONE;
					// Copy-all ignores both pins
					st_nxt.copy_r = st_r.copy_all_frames_mode_r || internal_match_in
						|| ext_ok;
					st_nxt.ari_r = internal_match_in || (ext_ok && !st_r.copy_all_frames_mode_r
						&& token_ring_mode_out);
				end
			end
			DEC_DONE: begin
				if (frame_end_in) begin
					st_nxt.dec_r = DEC_IDLE;
					st_nxt.copy_r = 1'h0;
					st_nxt.ari_r = 1'h0;
				end
			end
			default: st_nxt.dec_r = DEC_IDLE;
		endcase
		st_nxt.rdata_r = '0;
		if (reg_rd_in) begin
			if (reg_addr_in == CTRL_OFFSET) begin
				st_nxt.rdata_r[CTRL_CAF_BIT] = st_r.copy_all_frames_mode_r;
			end else if (reg_addr_in == STATUS_OFFSET) begin
				st_nxt.rdata_r[STAT_MODE_LSB +: STAT_MODE_W] = st_r.mode_r;
				st_nxt.rdata_r[STAT_TEST_BIT] = test_mode;
				st_nxt.rdata_r[STAT_STATE_LSB +: STAT_STATE_W] = st_r.dec_r;
				st_nxt.rdata_r[STAT_COPY_BIT] = st_r.copy_r;
				st_nxt.rdata_r[STAT_ARI_BIT] = st_r.ari_r;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= '{mode_r: MODE_RESERVED, copy_all_frames_mode_r: CTRL_CAF_RESET,
				dec_r: DEC_IDLE, copy_r: 1'h0, ari_r: 1'h0, rdata_r: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_out = st_r.rdata_r;
	assign net_mode_out = st_r.mode_r;
	assign token_ring_mode_out = (st_r.mode_r == MODE_TR_16) || (st_r.mode_r == MODE_TR_4);
	assign full_duplex_out = st_r.mode_r == MODE_ETH_FULL;
	assign mode_reserved_out = st_r.mode_r == MODE_RESERVED;
	// Pad drivers float while this is low
	assign outputs_enable_out = !test_mode;
	assign input_pullup_en_out = !test_mode;
	assign test_pullup_en_out = 1'h1;
	assign copy_frame_out = st_r.copy_r;
	assign addr_recognized_frame_copied_bits_out = st_r.ari_r;
	assign copy_all_frames_mode_out = st_r.copy_all_frames_mode_r;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	logic decide_now;
	assign decide_now = st_r.dec_r == DEC_ARMED && copy_decide_in && !frame_end_in;

	fail_blocks_ext_a: assert property (decide_now && fail_s && !internal_match_in
		&& !st_r.copy_all_frames_mode_r |=> !copy_frame_out && !addr_recognized_frame_copied_bits_out)
		else $error("fail input did not block the copy");
	both_high_a: assert property (decide_now && fail_s && match_s && !internal_match_in
		&& !st_r.copy_all_frames_mode_r |=> !copy_frame_out)
		else $error("fail did not take priority over match");
	ext_match_copy_a: assert property (decide_now && match_s && !fail_s && token_ring_mode_out
		&& !st_r.copy_all_frames_mode_r |=> copy_frame_out && addr_recognized_frame_copied_bits_out)
		else $error("external match did not copy");
	armed_no_copy_a: assert property (decide_now && !match_s && !fail_s && !internal_match_in
		&& !st_r.copy_all_frames_mode_r |=> !copy_frame_out)
		else $error("armed state copied a frame");
	internal_match_a: assert property (decide_now && internal_match_in
		|=> addr_recognized_frame_copied_bits_out)
		else $error("internal match lost its bits");
	copy_all_a: assert property (decide_now && st_r.copy_all_frames_mode_r
		|=> copy_frame_out && (addr_recognized_frame_copied_bits_out == $past(internal_match_in)))
		else $error("copy-all mode did not ignore the pins");
	decision_hold_a: assert property (st_r.dec_r == DEC_DONE && !frame_end_in
		|=> $stable(copy_frame_out) && $stable(addr_recognized_frame_copied_bits_out))
		else $error("decision changed within the frame");
	mode_frozen_a: assert property (!adapter_reset_in && !$past(adapter_reset_in)
		|-> $stable(net_mode_out))
		else $error("mode changed outside adapter reset");
	test_float_a: assert property (test_mode |-> !outputs_enable_out && !input_pullup_en_out
		&& test_pullup_en_out)
		else $error("test mode did not float outputs");
	ring_decode_a: assert property (adapter_reset_in && pins_s[IX_SEL2] && pins_s[IX_SEL1]
		|=> token_ring_mode_out)
		else $error("ring code not decoded");

	ext_copy_c: cover property (decide_now && ext_ok ##1 copy_frame_out);
	fail_c: cover property (decide_now && fail_s && match_s);
	caf_c: cover property (decide_now && st_r.copy_all_frames_mode_r);
	test_c: cover property (test_mode);

endmodule : net_mode_select_ext_match

`default_nettype wire

// ==== design/pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [WIDTH-1:0] pins_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1_r;
		logic [WIDTH-1:0] stage2_r;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	// First stage feeds only the second stage
	always_comb begin
		st_nxt.stage1_r = pins_in;
		st_nxt.stage2_r = st_r.stage1_r;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r <= {RESET_VAL, RESET_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.stage2_r;

endmodule : pin_sync

`default_nettype wire

// ==== pkg/netsel_pkg.sv ====
package netsel_pkg;

	// Decoded network mode; the reset value is the reserved code
	typedef enum logic [2:0] {
		MODE_ETH_FULL = 3'h0,
		MODE_TR_16 = 3'h1,
		MODE_ETH_HALF = 3'h3,
		MODE_TR_4 = 3'h2,
		MODE_RESERVED = 3'h6
	} net_mode_t;

	// Per-frame decision sequence, Gray along idle, armed, decided
	typedef enum logic [1:0] {
		DEC_IDLE = 2'h0,
		DEC_ARMED = 2'h1,
		DEC_DONE = 2'h3
	} dec_state_t;

	localparam int REG_ADDR_W = 4;
	localparam int REG_DATA_W = 8;

	localparam logic [REG_ADDR_W-1:0] CTRL_OFFSET = 4'h0;
	localparam logic [REG_ADDR_W-1:0] STATUS_OFFSET = 4'h4;

	// Control register fields
	localparam int CTRL_CAF_BIT = 0;
	localparam logic CTRL_CAF_RESET = 1'h0;

	// Status register fields
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_MODE_W = 3;
	localparam int STAT_TEST_BIT = 3;
	localparam int STAT_STATE_LSB = 4;
	localparam int STAT_STATE_W = 2;
	localparam int STAT_COPY_BIT = 6;
	localparam int STAT_ARI_BIT = 7;

	// Synchronised input vector layout
	localparam int SYNC_W = 8;
	localparam int IX_SEL0 = 0;
	localparam int IX_SEL1 = 1;
	localparam int IX_SEL2 = 2;
	localparam int IX_TEST_A = 3;
	localparam int IX_TEST_B = 4;
	localparam int IX_TEST_C = 5;
	localparam int IX_FAIL = 6;
	localparam int IX_MATCH = 7;

	// Pins idle high through their pullups
	localparam logic [SYNC_W-1:0] SYNC_RESET = 8'hff;

endpackage : netsel_pkg

// ==== test/ext_checker_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// Address checker beside the block; when not fitted its pins float to the pullups
module ext_checker_model (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic fitted_in,
	input wire logic [1:0] verdict_in,
	output logic match_out,
	output logic fail_out
);
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			match_out <= 1'h1;
			fail_out <= 1'h1;
		end else if (!fitted_in) begin
			match_out <= 1'h1;
			fail_out <= 1'h1;
		end else begin
			match_out <= verdict_in[1];
			fail_out <= verdict_in[0];
		end
	end
endmodule : ext_checker_model

`default_nettype wire

// ==== test/net_mode_select_ext_match_tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module net_mode_select_ext_match_tb;
	import netsel_pkg::*;
	logic clk_in = 0, rst_b_in = 0, adapter_reset_in = 1;
	logic sel0 = 0, sel1 = 0, sel2 = 1, ta = 1, tb = 1, fitted = 1;
	logic [1:0] verdict = 2'h0;
	logic match_w, fail_w, f_start = 0, f_decide = 0, f_end = 0, int_match = 0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h0, rdata;
	logic wr = 0, rd = 0;
	logic [2:0] mode_w, mode_exp;
	logic tr_w, fd_w, res_w, oe_w, pu_w, tpu_w, copy_w, ari_w, caf_w;
	int err_count = 0, cmp_count = 0;

	ext_checker_model partner (.clk_in(clk_in), .rst_b_in(rst_b_in), .fitted_in(fitted),
		.verdict_in(verdict), .match_out(match_w), .fail_out(fail_w));
	net_mode_select_ext_match uut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.adapter_reset_in(adapter_reset_in), .net_select_0(sel0), .net_select_1(sel1),
		.net_select_2(sel2), .board_test_in_a(ta), .board_test_in_b(tb),
		.board_test_in_c(1'h1), .ext_no_match_n(fail_w), .ext_match_found(match_w),
		.frame_start_in(f_start), .copy_decide_in(f_decide), .frame_end_in(f_end),
		.internal_match_in(int_match), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .net_mode_out(mode_w),
		.token_ring_mode_out(tr_w), .full_duplex_out(fd_w), .mode_reserved_out(res_w),
		.outputs_enable_out(oe_w), .input_pullup_en_out(pu_w), .test_pullup_en_out(tpu_w),
		.copy_frame_out(copy_w), .addr_recognized_frame_copied_bits_out(ari_w),
		.copy_all_frames_mode_out(caf_w));

	initial begin
		forever #10 clk_in = ~clk_in;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk_in);
		wr <= 0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd <= 1;
		@(posedge clk_in);
		rd <= 0;
		#1;
		check(rdata, exp);
	endtask : reg_read

	// Pins settle through the synchroniser before the frame opens; exp is {copy, ari}
	task automatic frame(input logic [1:0] v, input logic im, input logic [1:0] exp);
		verdict <= v;
		int_match <= im;
		tick(4);
		@(posedge clk_in);
		f_start <= 1;
		@(posedge clk_in);
		f_start <= 0;
		f_decide <= 1;
		@(posedge clk_in);
		f_decide <= 0;
		#1;
		check({6'h0, copy_w, ari_w}, {6'h0, exp});
		reg_read(STATUS_OFFSET, {exp[0], exp[1], 2'h3, 1'h0, mode_exp});
		verdict <= ~v;
		int_match <= ~im;
		tick(4);
		@(posedge clk_in);
		f_decide <= 1;
		@(posedge clk_in);
		f_decide <= 0;
		f_end <= 1;
		#1;
		check({6'h0, copy_w, ari_w}, {6'h0, exp});
		@(posedge clk_in);
		f_end <= 0;
		#1;
		check({6'h0, copy_w, ari_w}, 8'h0);
	endtask : frame

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	initial begin
		#300000;
		err_count++;
		results();
	end

	initial begin
		tick(2);
		rst_b_in = 1;
		check({4'h0, res_w, mode_w}, {4'h0, 1'h1, MODE_RESERVED});
		// Synchroniser leaves reset at the pullup level, so the straps read all high at first
		reg_read(STATUS_OFFSET, 8'h02);
		reg_read(CTRL_OFFSET, 8'h00);
		reg_read(4'h9, 8'h00);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			sel0 <= i[1];
			sel1 <= i[0];
			tick(5);
			check({5'h0, mode_w}, {6'h0, i[1], i[1] ^ i[0]});
			check({6'h0, tr_w, fd_w}, {6'h0, i[0], i == 0});
		end
		@(posedge clk_in);
		sel2 <= 0;
		tick(5);
		check({4'h0, res_w, mode_w}, {4'h0, 1'h1, MODE_RESERVED});
		@(posedge clk_in);
		sel2 <= 1;
		tick(5);
		adapter_reset_in <= 0;
		mode_exp = MODE_TR_4;
		// Straps moved outside adapter reset on purpose: the latched mode must not follow
		sel0 <= 0;
		tick(5);
		check({5'h0, mode_w}, {5'h0, mode_exp});
		sel0 <= 1;
		ta <= 0;
		tick(5);
		check({5'h0, oe_w, pu_w, tpu_w}, 8'h07);
		tb <= 0;
		tick(5);
		check({5'h0, oe_w, pu_w, tpu_w}, 8'h01);
		reg_read(STATUS_OFFSET, 8'h0a);
		ta <= 1;
		tb <= 1;
		frame(2'h0, 0, 2'h0);
		frame(2'h2, 0, 2'h3);
		frame(2'h1, 0, 2'h0);
		frame(2'h3, 0, 2'h0);
		frame(2'h1, 1, 2'h3);
		fitted <= 0;
		frame(2'h2, 0, 2'h0);
		fitted <= 1;
		reg_write(CTRL_OFFSET, 8'h01);
		reg_read(CTRL_OFFSET, 8'h01);
		check({7'h0, caf_w}, 8'h01);
		frame(2'h1, 0, 2'h2);
		frame(2'h2, 1, 2'h3);
		reg_write(CTRL_OFFSET, 8'h00);
		frame(2'h2, 0, 2'h3);
		check({7'h0, caf_w}, 8'h00);
		results();
	end
endmodule : net_mode_select_ext_match_tb

`default_nettype wire
